// *** core_clock_sync.sv ***
// Purpose: Shared constants and types, plus the pin input synchroniser
// Assumes: One clock, i_ref_clk at 40 MHz, synchronous active high reset
// Notes:   Filtered output moves only when stages two and three agree

`timescale 1ns/100ps
`default_nettype none

// ========================================================================
// Package
package core_clock_pkg;

    // Strap codes and multipliers
    localparam int          STRAP_W        = 3;
    localparam int          MULT_W         = 4;
    localparam logic [2:0]  CODE_X4        = 3'h0;
    localparam logic [2:0]  CODE_X5        = 3'h1;
    localparam logic [2:0]  CODE_X6        = 3'h2;
    localparam logic [2:0]  CODE_X7        = 3'h3;
    localparam logic [2:0]  CODE_X8        = 3'h4;
    localparam logic [2:0]  CODE_X10       = 3'h5;
    localparam logic [2:0]  CODE_X12       = 3'h6;
    localparam logic [2:0]  CODE_RESERVED  = 3'h7;
    localparam logic [3:0]  MULT_X4        = 4'h4;
    localparam logic [3:0]  MULT_X5        = 4'h5;
    localparam logic [3:0]  MULT_X6        = 4'h6;
    localparam logic [3:0]  MULT_X7        = 4'h7;
    localparam logic [3:0]  MULT_X8        = 4'h8;
    localparam logic [3:0]  MULT_X10       = 4'ha;
    localparam logic [3:0]  MULT_X12       = 4'hc;
    localparam logic [3:0]  MULT_NONE      = 4'h0;

    // Timing: loop lock wait, least time so rounded up
    localparam int SYS_CLK_PERIOD_PS = 25000;
    localparam int LOCK_TIME_NS      = 50000;
    localparam int LOCK_CYCLES       =
        (LOCK_TIME_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
    localparam int LOCK_CNT_W        = 12;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_LOCK  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_BAD   = 4'b1000
    } seq_state_type;

    // Clock configuration seen by the rest of the chip
    typedef struct packed {
        logic [3:0] core_mult;     // Core clock / system clock
        logic [3:0] instr_mult;    // Instruction rate / system clock
        logic [3:0] bus_mult_x2;   // 2 * on-chip bus clock / system clock
    } clk_cfg_type;

    localparam clk_cfg_type CFG_RESET = '{4'h0, 4'h0, 4'h0};

    function automatic logic [3:0] ratio_of(input logic [2:0] code);
        case (code)
            CODE_X4:  ratio_of = MULT_X4;
            CODE_X5:  ratio_of = MULT_X5;
            CODE_X6:  ratio_of = MULT_X6;
            CODE_X7:  ratio_of = MULT_X7;
            CODE_X8:  ratio_of = MULT_X8;
            CODE_X10: ratio_of = MULT_X10;
            CODE_X12: ratio_of = MULT_X12;
            default:  ratio_of = MULT_NONE;
        endcase
    endfunction

endpackage : core_clock_pkg

// ========================================================================
// Three stage synchroniser with agreement filter
module core_clock_sync #(
    parameter int           WIDTH = 1,
    parameter logic [31:0]  INIT  = 32'h0000_0000
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Stage one feeds stage two only, for metastability settling
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            stage1_reg <= INIT[WIDTH-1:0];
            stage2_reg <= INIT[WIDTH-1:0];
            stage3_reg <= INIT[WIDTH-1:0];
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sync <= INIT[WIDTH-1:0];
        end else begin
            for (int b = 0; b < WIDTH; b++) begin
                if (stage2_reg[b] == stage3_reg[b]) begin
                    o_sync[b] <= stage3_reg[b];
                end
            end
        end
    end
endmodule // core_clock_sync

`default_nettype wire

// *** core_clock_ratio_reset.sv ***
// Purpose: Core clock ratio strap decode and reset sequencing
// Assumes: i_ref_clk is the system clock; the loop model waits a lock time
// Notes:   Core clock itself is analog; this block sets its multiplier
//
// What this block does
// - Core clock is system clock times strap ratio; 111 reserved.
// - Instruction rate equals core clock rate.
// - Reset input forces known state with execution idle.
// - Reset-done output signals internal reset sequence complete.
// - All outputs three-stated while reset is in effect.
// - Asynchronous inputs pass a synchroniser before use.
// - Core clock loop is referenced and phase locked to system clock.
// - On-chip bus runs at half the core clock rate.

`timescale 1ns/100ps
`default_nettype none

module core_clock_ratio_reset
    import core_clock_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_CYCLES
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire logic         i_rst_in_n,
    input  wire logic         i_por_in,
    input  wire logic [2:0]   i_core_ratio_strap,
    output var clk_cfg_type   o_clk_cfg,
    output logic              o_pll_locked,
    output logic              o_rst_out,
    output logic              o_exec_idle,
    output logic              o_pad_oe_n,
    output logic              o_ratio_invalid,
    output logic              o_dram_init
);

    // ====================================================================
    // Input synchronisers
    logic       rst_in_n_sync;
    logic       por_in_sync;
    logic [2:0] strap_sync;

    core_clock_sync #(.WIDTH(2), .INIT(32'h0000_0000)) u_sync_ctl (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   ({i_rst_in_n, i_por_in}),
        .o_sync    ({rst_in_n_sync, por_in_sync})
    );

    core_clock_sync #(.WIDTH(STRAP_W), .INIT(32'h0000_0000)) u_sync_strap (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   (i_core_ratio_strap),
        .o_sync    (strap_sync)
    );

    // Device reset: block reset or board reset pin held low
    // One extra stage so the straps have settled before release
    logic dev_rst_reg;
    logic dev_rst;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            dev_rst_reg <= 1'b1;
        end else begin
            dev_rst_reg <= ~rst_in_n_sync;
        end
    end

    assign dev_rst = i_rst | dev_rst_reg;

    // ====================================================================
    // Strap capture
    // Straps only follow the pin while in reset, so later glitches
    // cannot disturb a running core clock
    logic [2:0] strap_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            strap_reg <= CODE_X4;
        end else if (dev_rst) begin
            strap_reg <= strap_sync;
        end
    end

    // ====================================================================
    // Sequencer
    seq_state_type          state_reg;
    seq_state_type          state_next;
    logic [LOCK_CNT_W-1:0]  lock_cnt_reg;
    logic                   lock_done;

    assign lock_done = (lock_cnt_reg == LOCK_CNT_W'(LOCK_WAIT - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (!dev_rst) begin
                    if (strap_reg == CODE_RESERVED) begin
                        state_next = ST_BAD;
                    end else begin
                        state_next = ST_LOCK;
                    end
                end
            end
            ST_LOCK: begin
                if (lock_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:  state_next = state_reg;
            ST_BAD:  state_next = state_reg;
            default: state_next = ST_RESET;
        endcase
        if (dev_rst) begin
            state_next = ST_RESET;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lock wait counter, restarted on every entry to the lock state
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || state_reg != ST_LOCK) begin
            lock_cnt_reg <= '0;
        end else if (!lock_done) begin
            lock_cnt_reg <= lock_cnt_reg + LOCK_CNT_W'(1);
        end
    end

    // ====================================================================
    // Outputs
    logic [3:0] mult;
    assign mult = ratio_of(strap_reg);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_clk_cfg <= CFG_RESET;
        end else if (state_next == ST_RESET || state_next == ST_BAD) begin
            o_clk_cfg <= CFG_RESET;
        end else begin
            o_clk_cfg.core_mult   <= mult;
            o_clk_cfg.instr_mult  <= mult;
            o_clk_cfg.bus_mult_x2 <= mult;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pll_locked <= 1'b0;
            o_rst_out    <= 1'b0;
            o_exec_idle  <= 1'b1;
            o_pad_oe_n   <= 1'b1;
        end else begin
            o_pll_locked <= (state_next == ST_RUN);
            o_rst_out    <= (state_next == ST_RUN);
            o_exec_idle  <= (state_next != ST_RUN);
            o_pad_oe_n   <= (state_next != ST_RUN);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_ratio_invalid <= 1'b0;
            o_dram_init     <= 1'b0;
        end else begin
            o_ratio_invalid <= (strap_reg == CODE_RESERVED);
            // Looped-back reset-done starts memory init
            o_dram_init     <= por_in_sync & ~dev_rst;
        end
    end

    // ====================================================================
    // Assertions
    a_reset_idle_pads: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        dev_rst |=> (o_pad_oe_n && o_exec_idle && !o_rst_out))
        else $error("Outputs not released to idle during reset");

    a_done_needs_lock: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_rst_out) |-> $past(state_reg) == ST_LOCK && $past(lock_done))
        else $error("Reset done rose without loop lock");

    a_lock_wait_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(state_reg == ST_LOCK) |-> lock_cnt_reg == '0)
        else $error("Lock counter not cleared on entry");

    a_reserved_blocks: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_ratio_invalid && !dev_rst) |-> !o_rst_out)
        else $error("Reset done with reserved strap");

    a_core_mult_map: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_rst_out && strap_reg == CODE_X10)
            |-> o_clk_cfg.core_mult == MULT_X10)
        else $error("Core multiplier does not match strap");

    a_instr_rate_same: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_clk_cfg.instr_mult == o_clk_cfg.core_mult)
        else $error("Instruction rate differs from core rate");

    a_bus_half_rate: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_clk_cfg.bus_mult_x2 == o_clk_cfg.core_mult)
        else $error("Bus clock not half of core clock");

    a_strap_frozen: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (!dev_rst && !$past(dev_rst)) |=> $stable(strap_reg))
        else $error("Strap changed outside reset");

    a_rst_pin_sync: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $fell(i_rst_in_n) ##1 !i_rst_in_n [*3] |=> ##[0:2] dev_rst)
        else $error("Reset pin not seen through synchroniser");

    c_normal_boot: cover property (
        @(posedge i_ref_clk) disable iff (i_rst) $rose(o_rst_out));
    c_bad_strap: cover property (
        @(posedge i_ref_clk) disable iff (i_rst) $rose(state_reg == ST_BAD));
    c_warm_reset: cover property (
        @(posedge i_ref_clk) disable iff (i_rst) o_rst_out ##1 !o_rst_out);
    c_dram_start: cover property (
        @(posedge i_ref_clk) disable iff (i_rst) $rose(o_dram_init));

endmodule // core_clock_ratio_reset

`default_nettype wire

// *** board_supervisor.sv ***
// Purpose: Board side model: reset supervisor, ratio straps, por loop
// Assumes: Driven from the system clock, commands from the bench
// Notes:   Late strap change only when the bench asks for it

`timescale 1ns/100ps
`default_nettype none

// ========================================================================
// Board supervisor
module board_supervisor #(
    parameter int MIN_HOLD = 6
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_hold_req,
    input  wire logic [2:0] i_strap_req,
    input  wire logic       i_late_strap,
    input  wire logic       i_rst_done,
    output logic            o_rst_in_n,
    output logic [2:0]      o_strap,
    output logic            o_por_in
);
    logic [3:0] hold_cnt_reg;

    initial begin
        o_rst_in_n   = 1'b0;
        o_strap      = 3'h0;
        hold_cnt_reg = 4'h0;
    end

    // Reset pin held a minimum time after each request
    always @(posedge i_ref_clk) begin
        if (i_hold_req) begin
            hold_cnt_reg <= 4'(MIN_HOLD);
            o_rst_in_n   <= 1'b0;
        end else if (hold_cnt_reg != 4'h0) begin
            hold_cnt_reg <= hold_cnt_reg - 4'h1;
        end else begin
            o_rst_in_n <= 1'b1;
        end
        // Straps move only in reset unless a refusal test wants it
        if (!o_rst_in_n || i_late_strap) begin
            o_strap <= i_strap_req;
        end
    end

    // Reset-done looped straight back to the memory reset pin
    assign o_por_in = i_rst_done;
endmodule // board_supervisor

`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for ratio decode and reset sequencing
// Assumes: LOCK_WAIT cut to 8 cycles to keep the run short
// Notes:   Inputs move 2 ns after the rising edge

`timescale 1ns/100ps
`default_nettype none

// ========================================================================
// Bench
module testbench;
    import core_clock_pkg::*;

    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        hold_req = 1'b1;
    logic        late_strap = 1'b0;
    logic [2:0]  strap_req = 3'h0;
    wire logic   rst_in_n;
    wire logic   por_in;
    wire logic [2:0] strap;
    clk_cfg_type o_clk_cfg;
    logic        o_pll_locked, o_rst_out, o_exec_idle;
    logic        o_pad_oe_n, o_ratio_invalid, o_dram_init;
    int          errors = 0;
    int          comparisons = 0;
    logic [3:0]  mults [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc};

    always #12.5 i_ref_clk = ~i_ref_clk;

    core_clock_ratio_reset #(.LOCK_WAIT(8)) DUT (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rst_in_n(rst_in_n),
        .i_por_in(por_in), .i_core_ratio_strap(strap),
        .o_clk_cfg(o_clk_cfg), .o_pll_locked(o_pll_locked),
        .o_rst_out(o_rst_out), .o_exec_idle(o_exec_idle),
        .o_pad_oe_n(o_pad_oe_n), .o_ratio_invalid(o_ratio_invalid),
        .o_dram_init(o_dram_init));

    board_supervisor #(.MIN_HOLD(6)) board (
        .i_ref_clk(i_ref_clk), .i_hold_req(hold_req),
        .i_strap_req(strap_req), .i_late_strap(late_strap),
        .i_rst_done(o_rst_out), .o_rst_in_n(rst_in_n),
        .o_strap(strap), .o_por_in(por_in));

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask

    task automatic check1(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic check_cfg(input clk_cfg_type e);
        comparisons++;
        if (o_clk_cfg !== e) begin
            errors++;
            $display("CHECK FAILED clk_cfg expected %h seen %h", e, o_clk_cfg);
        end
    endtask

    // Board reset with a strap code, then release
    task automatic board_reset(input logic [2:0] code);
        strap_req = code;
        hold_req  = 1'b1;
        step(8);
        check1("pad_oe_n in reset", 1'b1, o_pad_oe_n);
        check1("exec_idle in reset", 1'b1, o_exec_idle);
        check1("rst_out in reset", 1'b0, o_rst_out);
        check1("dram_init in reset", 1'b0, o_dram_init);
        hold_req = 1'b0;
    endtask

    // Each valid code reaches run with its multiplier
    task automatic ratio_run(input logic [2:0] code);
        int n;
        board_reset(code);
        n = 0;
        while (o_clk_cfg.core_mult === 4'h0 && n < 40) begin
            step(1);
            n++;
        end
        check_cfg('{mults[code], mults[code], mults[code]});
        check1("rst_out before lock", 1'b0, o_rst_out);
        check1("locked before lock", 1'b0, o_pll_locked);
        n = 0;
        while (o_rst_out !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        check1("rst_out", 1'b1, o_rst_out);
        check1("locked", 1'b1, o_pll_locked);
        check1("exec_idle", 1'b0, o_exec_idle);
        check1("pad_oe_n", 1'b0, o_pad_oe_n);
        check1("ratio_invalid", 1'b0, o_ratio_invalid);
        step(8);
        check1("dram_init", 1'b1, o_dram_init);
    endtask

    // Reserved code never completes reset
    task automatic reserved_code;
        board_reset(CODE_RESERVED);
        step(40);
        check1("invalid", 1'b1, o_ratio_invalid);
        check1("rst_out reserved", 1'b0, o_rst_out);
        check1("pad_oe_n reserved", 1'b1, o_pad_oe_n);
        check1("dram_init reserved", 1'b0, o_dram_init);
        check_cfg(CFG_RESET);
    endtask

    // Strap moved while running is ignored
    task automatic late_strap_change;
        ratio_run(CODE_X10);
        late_strap = 1'b1;
        strap_req  = CODE_X5;
        step(12);
        late_strap = 1'b0;
        check_cfg('{MULT_X10, MULT_X10, MULT_X10});
        check1("rst_out kept", 1'b1, o_rst_out);
    endtask

    // Block reset while held in the bad state clears state; straps are read afresh
    task automatic block_reset;
        i_rst = 1'b1;
        step(4);
        check1("invalid in block reset", 1'b0, o_ratio_invalid);
        check1("rst_out in block reset", 1'b0, o_rst_out);
        check1("pad_oe_n in block reset", 1'b1, o_pad_oe_n);
        check_cfg(CFG_RESET);
        i_rst = 1'b0;
        step(2);
        check1("exec_idle after block reset", 1'b1, o_exec_idle);
        step(40);
        check1("invalid after block reset", 1'b1, o_ratio_invalid);
        check1("rst_out after block reset", 1'b0, o_rst_out);
        check_cfg(CFG_RESET);
    endtask

    task automatic test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        step(4);
        i_rst = 1'b0;
        for (int c = 0; c < 7; c++) begin
            ratio_run(3'(c));
        end
        reserved_code();
        block_reset();
        late_strap_change();
        ratio_run(CODE_X4);
        test_done();
    end

    initial begin
        #(25 * 5000);
        errors++;
        test_done();
    end
endmodule // testbench

`default_nettype wire
